// *** hw/bypass_contactor_sequencer.sv ***
// bypass contactor sequencer: moves the motor between converter and line
`timescale 1ns/1ps
`default_nettype none
// How it works
// - no-overlap: line closes after converter opened
// - phase lead from sync phase setpoint
// - no-overlap mode only from control source
// - model voltages; sync request enables sync
// - unsync out: inhibit, open converter, de-excite, close
// - unsync in: open line, wait, close converter
// - contactor commands never both closed unsync
// - control source: bypass follows command, return delay
// - speed source: bypass when setpoint above threshold
// - return when ramp input below threshold
// - fault source: fault to line, ack returns
// - restart acknowledge with fault gone needed to return
// - fault: inhibit, delay, open, deadtime, close line
// - fault gone: delay, open line, deadtime, close
// - feedback inputs index0 converter index1 line
// - no-overlap: synchronism reached checked before switching
// - sync request set at synchronised start
module bypass_contactor_sequencer
    import bypass_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [1:0]          bypass_mode_select,
    input  wire logic [2:0]          bypass_trigger_select,
    input  wire logic                bypass_command_input,
    input  wire logic [TIME_W-1:0]   bypass_dead_time,
    input  wire logic [TIME_W-1:0]   return_delay_time,
    input  wire logic [TIME_W-1:0]   bypass_delay_time,
    input  wire logic [SPEED_W-1:0]  bypass_speed_threshold,
    input  wire logic [SPEED_W-1:0]  speed_setpoint,
    input  wire logic [SPEED_W-1:0]  ramp_input_setpoint,
    input  wire logic                converter_fault,
    input  wire logic                on_command,
    input  wire logic [1:0]          contactor_feedback_input,
    input  wire logic [SYNC_W-1:0]   sync_status_word,
    input  wire logic [SPEED_W-1:0]  sync_phase_setpoint,
    output logic [CSW_W-1:0]         bypass_ctrl_status_word,
    output logic                     pulse_enable,
    output logic                     sync_enable_input,
    output logic [1:0]               sync_voltage_source_select,
    output logic [SPEED_W-1:0]       sync_phase_lead
);
    import bypass_pkg::*;

    seq_state_e        st_q, st_d;
    logic              conv_q, conv_d, line_q, line_d, syn_q, syn_d, pul_q, pul_d;
    logic              fltpath_q, fltpath_d;
    logic              t_start;
    logic [TIME_W-1:0] t_load;
    logic              t_done;
    logic              nooverlap, unsync, sel_ctrl_only;
    logic              want_out, want_in, fb_conv, fb_line, synced;

    bypass_timer #(.TICK_DIV(TICK_DIV)) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (t_start),
        .load_ms  (t_load),
        .done     (t_done)
    );

    always_comb begin
        fb_conv   = contactor_feedback_input[FB_CONV];
        fb_line   = contactor_feedback_input[FB_LINE];
        synced    = sync_status_word[SYNC_REACHED];
        nooverlap = (bypass_mode_select == MODE_SYNC_NOOV);
        unsync    = (bypass_mode_select == MODE_UNSYNC);
        sel_ctrl_only = (bypass_trigger_select == 3'h1);
        want_out = 1'b0;
        if (nooverlap) begin
            want_out = sel_ctrl_only && bypass_command_input;
        end else if (unsync) begin
            if (bypass_trigger_select[TRIG_CTRL] && bypass_command_input)
                want_out = 1'b1;
            if (bypass_trigger_select[TRIG_SPEED] && speed_setpoint > bypass_speed_threshold)
                want_out = 1'b1;
            if (bypass_trigger_select[TRIG_FAULT] && converter_fault)
                want_out = 1'b1;
        end
        // return condition per source; fault source also needs on command
        want_in = 1'b1;
        if (fltpath_q) begin
            want_in = !converter_fault && on_command;
        end else if (unsync && bypass_trigger_select[TRIG_SPEED]) begin
            want_in = ramp_input_setpoint < bypass_speed_threshold;
        end else begin
            want_in = !bypass_command_input;
        end
    end

    always_comb begin
        st_d      = st_q;
        conv_d    = conv_q;
        line_d    = line_q;
        syn_d     = syn_q;
        pul_d     = pul_q;
        fltpath_d = fltpath_q;
        t_start   = 1'b0;
        t_load    = bypass_dead_time;
        unique case (st_q)
            ST_CONV: begin
                conv_d = 1'b1;
                pul_d  = 1'b1;
                if (want_out && fb_conv) begin
                    fltpath_d = unsync && bypass_trigger_select[TRIG_FAULT] && converter_fault;
                    if (nooverlap) begin
                        syn_d = 1'b1;
                        st_d  = ST_SYNC_OUT;
                    end else begin
                        pul_d   = 1'b0;
                        t_start = 1'b1;
                        t_load  = fltpath_d ? bypass_delay_time : '0;
                        st_d    = ST_DELAY;
                    end
                end
            end
            ST_SYNC_OUT: begin
                if (!want_out) begin
                    syn_d = 1'b0;
                    st_d  = ST_CONV;
                end else if (synced) begin
                    conv_d = 1'b0;
                    pul_d  = 1'b0;
                    st_d   = ST_OPEN_CONV;
                end
            end
            ST_DELAY: begin
                if (t_done) begin
                    conv_d = 1'b0;
                    st_d   = ST_OPEN_CONV;
                end
            end
            ST_OPEN_CONV: begin
                if (!fb_conv) begin
                    t_start = 1'b1;
                    t_load  = nooverlap ? '0 : bypass_dead_time;
                    st_d    = ST_DEAD_OUT;
                end
            end
            ST_DEAD_OUT: begin
                if (t_done && !fb_conv && !conv_q) begin
                    line_d = 1'b1;
                    syn_d  = 1'b0;
                    st_d   = ST_CLOSE_LN;
                end
            end
            ST_CLOSE_LN: begin
                if (fb_line)
                    st_d = ST_LINE;
            end
            ST_LINE: begin
                if (want_in) begin
                    t_start = 1'b1;
                    t_load  = return_delay_time;
                    st_d    = ST_RET_DLY;
                end
            end
            ST_RET_DLY: begin
                if (!want_in) begin
                    st_d = ST_LINE;
                end else if (t_done) begin
                    line_d = 1'b0;
                    st_d   = ST_OPEN_LN;
                end
            end
            ST_OPEN_LN: begin
                if (!fb_line) begin
                    t_start = 1'b1;
                    t_load  = bypass_dead_time;
                    st_d    = ST_DEAD_IN;
                end
            end
            ST_DEAD_IN: begin
                if (t_done && !fb_line && !line_q) begin
                    conv_d    = 1'b1;
                    fltpath_d = 1'b0;
                    st_d      = ST_CONV;
                end
            end
            default: begin
                conv_d = 1'b0;
                line_d = 1'b0;
                st_d   = ST_CONV;
            end
        endcase
        if (line_d)
            conv_d = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q      <= ST_CONV;
            conv_q    <= 1'b0;
            line_q    <= 1'b0;
            syn_q     <= 1'b0;
            pul_q     <= 1'b0;
            fltpath_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            conv_q    <= conv_d;
            line_q    <= line_d;
            syn_q     <= syn_d;
            pul_q     <= pul_d;
            fltpath_q <= fltpath_d;
        end
    end

    // registered outputs
    logic [SPEED_W-1:0] lead_q;
    logic [1:0]         src_q;
    logic               on_line_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lead_q    <= '0;
            src_q     <= '0;
            on_line_q <= 1'b0;
        end else begin
            lead_q    <= sync_phase_setpoint;
            src_q     <= SYNC_SRC_MODEL;
            on_line_q <= (st_d == ST_LINE);
        end
    end

    always_comb begin
        bypass_ctrl_status_word                 = '0;
        bypass_ctrl_status_word[CSW_CONV_CLOSE] = conv_q;
        bypass_ctrl_status_word[CSW_LINE_CLOSE] = line_q;
        bypass_ctrl_status_word[CSW_SYNC_REQ]   = syn_q;
        bypass_ctrl_status_word[CSW_ON_LINE]    = on_line_q;
        pulse_enable               = pul_q;
        sync_enable_input          = syn_q;
        sync_voltage_source_select = src_q;
        sync_phase_lead            = lead_q;
    end
endmodule : bypass_contactor_sequencer
`default_nettype wire

// *** hw/bypass_pkg.sv ***
// constants and types shared by the bypass sequencer
package bypass_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned TIME_W         = 16;
    localparam int unsigned MS_US          = 1000;
    // time counts are in milliseconds; one tick per millisecond
    localparam int unsigned TICK_CYCLES    = CLK_HZ / MS_US;
    localparam int unsigned TICK_W         = 14;
    localparam int unsigned SPEED_W        = 16;
    // mode encodings
    localparam logic [1:0]  MODE_OFF       = 2'h0;
    localparam logic [1:0]  MODE_SYNC_OVL  = 2'h1;
    localparam logic [1:0]  MODE_SYNC_NOOV = 2'h2;
    localparam logic [1:0]  MODE_UNSYNC    = 2'h3;
    // trigger select bit positions
    localparam int unsigned TRIG_CTRL      = 0;
    localparam int unsigned TRIG_SPEED     = 1;
    localparam int unsigned TRIG_FAULT     = 2;
    // control/status word bit positions
    localparam int unsigned CSW_CONV_CLOSE = 0;
    localparam int unsigned CSW_LINE_CLOSE = 1;
    localparam int unsigned CSW_SYNC_REQ   = 2;
    localparam int unsigned CSW_ON_LINE    = 3;
    localparam int unsigned CSW_W          = 4;
    // feedback indices
    localparam int unsigned FB_CONV        = 0;
    localparam int unsigned FB_LINE        = 1;
    // sync status bit for synchronism reached
    localparam int unsigned SYNC_REACHED   = 2;
    localparam int unsigned SYNC_W         = 4;
    // internal model voltages as sync source
    localparam logic [1:0]  SYNC_SRC_MODEL = 2'h1;

    typedef enum logic [9:0] {
        ST_CONV      = 10'h001,
        ST_SYNC_OUT  = 10'h002,
        ST_DELAY     = 10'h004,
        ST_OPEN_CONV = 10'h008,
        ST_DEAD_OUT  = 10'h010,
        ST_CLOSE_LN  = 10'h020,
        ST_LINE      = 10'h040,
        ST_RET_DLY   = 10'h080,
        ST_OPEN_LN   = 10'h100,
        ST_DEAD_IN   = 10'h200
    } seq_state_e;
endpackage : bypass_pkg

// *** hw/bypass_timer.sv ***
// millisecond tick divider and delay counter
`timescale 1ns/1ps
`default_nettype none
module bypass_timer
    import bypass_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic [TIME_W-1:0] load_ms,
    output logic                   done
);
    logic [TICK_W-1:0] div_q, div_d;
    logic [TIME_W-1:0] cnt_q, cnt_d;
    logic              tick;

    always_comb begin
        tick  = (div_q == TICK_W'(TICK_DIV - 1));
        div_d = tick ? '0 : div_q + 1'b1;
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = load_ms;
            div_d = '0;
        end else if (tick && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        done = (cnt_q == '0) && !start;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_q <= '0;
            cnt_q <= '0;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : bypass_timer
`default_nettype wire

// *** tb/bypass_contactor_sequencer_properties.sv ***
// checker for the bypass contactor sequencer ports
`timescale 1ns/1ps
`default_nettype none
module bypass_checker
    import bypass_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic [1:0]         bypass_mode_select,
    input wire logic [2:0]         bypass_trigger_select,
    input wire logic [TIME_W-1:0]  bypass_dead_time,
    input wire logic [1:0]         contactor_feedback_input,
    input wire logic [SPEED_W-1:0] sync_phase_setpoint,
    input wire logic [CSW_W-1:0]   bypass_ctrl_status_word,
    input wire logic               pulse_enable,
    input wire logic               sync_enable_input,
    input wire logic [1:0]         sync_voltage_source_select,
    input wire logic [SPEED_W-1:0] sync_phase_lead
);
    logic [31:0] low_cnt_q;
    logic [31:0] low_cnt_d;
    wire logic [CSW_W-1:0] w = bypass_ctrl_status_word;
    wire logic [1:0]       fb = contactor_feedback_input;
    wire logic             unsync_m = (bypass_mode_select == MODE_UNSYNC);
    // cycles the converter contactor has been seen open
    always_comb low_cnt_d = fb[FB_CONV] ? 32'h0 : low_cnt_q + 32'h1;
    always_ff @(posedge core_clk) low_cnt_q <= rst ? 32'h0 : low_cnt_d;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_NO_BOTH: assert property (!(w[CSW_CONV_CLOSE] && w[CSW_LINE_CLOSE]))
        else $error("both contactors commanded closed");
    AST_LINE_AFTER_OPEN: assert property ($rose(w[CSW_LINE_CLOSE]) |-> !fb[FB_CONV])
        else $error("line closed before converter open");
    AST_DEAD_WAIT: assert property ($rose(w[CSW_LINE_CLOSE]) && unsync_m |->
        low_cnt_q >= bypass_dead_time * TICK_DIV)
        else $error("dead time cut short");
    AST_CONV_AFTER_LINE: assert property ($rose(w[CSW_CONV_CLOSE]) |-> !fb[FB_LINE])
        else $error("converter closed before line open");
    AST_PULSE_FIRST: assert property ($fell(w[CSW_CONV_CLOSE]) && unsync_m |->
        !$past(pulse_enable))
        else $error("converter opened with pulses on");
    AST_LINE_NO_PULSE: assert property (w[CSW_LINE_CLOSE] |-> !pulse_enable)
        else $error("pulses on while on line");
    AST_ON_LINE_FB: assert property ($rose(w[CSW_ON_LINE]) |-> $past(fb[FB_LINE]))
        else $error("on line without feedback");
    AST_SYNC_EN: assert property (sync_enable_input == w[CSW_SYNC_REQ])
        else $error("sync enable differs from request");
    AST_SYNC_SRC: assert property ($rose(w[CSW_SYNC_REQ]) |->
        bypass_mode_select == MODE_SYNC_NOOV && bypass_trigger_select == 3'h1)
        else $error("sync request from wrong source");
    AST_MODEL_SRC: assert property (!$past(rst) |->
        sync_voltage_source_select == SYNC_SRC_MODEL)
        else $error("sync source not model voltages");
    AST_LEAD: assert property (!$past(rst) |->
        sync_phase_lead == $past(sync_phase_setpoint))
        else $error("phase lead not setpoint");
endmodule : bypass_checker
bind bypass_contactor_sequencer bypass_checker #(.TICK_DIV(TICK_DIV)) u_chk (.core_clk, .rst,
    .bypass_mode_select, .bypass_trigger_select, .bypass_dead_time, .contactor_feedback_input,
    .sync_phase_setpoint, .bypass_ctrl_status_word, .pulse_enable, .sync_enable_input,
    .sync_voltage_source_select, .sync_phase_lead);
`default_nettype wire

// *** tb/contactor_model.sv ***
// two contactors with feedback contacts, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module contactor_model (
    input  wire logic     core_clk,
    input  wire logic     slow,
    input  wire logic [1:0] close_cmd,
    output logic [1:0]    closed
);
    int cnt [2];
    initial closed = 2'h0;
    // index 0 converter, index 1 line
    always @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (close_cmd[i] === closed[i]) cnt[i] <= 0;
            else if (cnt[i] >= (slow ? 20 : 2)) begin
                closed[i] <= close_cmd[i];
                cnt[i] <= 0;
            end else cnt[i] <= cnt[i] + 1;
        end
    end
endmodule : contactor_model
`default_nettype wire

// *** tb/tb_bypass_contactor_sequencer.sv ***
// testbench for the bypass contactor sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_bypass_contactor_sequencer;
    import bypass_pkg::*;
    logic core_clk = 0, rst = 1, cmd = 0, fault = 0, on_cmd = 0, slow = 0;
    logic [1:0]  mode = MODE_OFF;
    logic [2:0]  trig = 3'h0;
    logic [15:0] thr = 16'h0, spd = 16'h0, ramp = 16'h0, phase = 16'h1234, lead;
    logic [3:0]  sync_w = 4'h0;
    logic [3:0]  csw;
    logic [1:0]  fb, src;
    logic        pulse, sync_en;
    wire  [4:0]  st = {pulse, csw};
    int error_cnt = 0, samples_checked = 0, c;
    always #50 core_clk = ~core_clk;
    bypass_contactor_sequencer #(.TICK_DIV(4)) u_dut (.core_clk, .rst, .bypass_mode_select(mode),
        .bypass_trigger_select(trig), .bypass_command_input(cmd),
        .bypass_dead_time(16'h2),
        .return_delay_time(16'h3), .bypass_delay_time(16'h2), .bypass_speed_threshold(thr),
        .speed_setpoint(spd), .ramp_input_setpoint(ramp), .converter_fault(fault),
        .on_command(on_cmd), .contactor_feedback_input(fb), .sync_status_word(sync_w),
        .sync_phase_setpoint(phase), .bypass_ctrl_status_word(csw), .pulse_enable(pulse),
        .sync_enable_input(sync_en), .sync_voltage_source_select(src), .sync_phase_lead(lead));
    contactor_model u_cont (.core_clk, .slow, .close_cmd(csw[1:0]), .closed(fb));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wait_bit(int idx, logic v);
        c = 0;
        while (st[idx] !== v && c < 3000) begin
            step(1);
            c++;
        end
        chk("status bit", 16'(v), 16'(st[idx]));
    endtask : wait_bit
    task automatic t_unsync_ctrl();
        mode = MODE_UNSYNC; trig = 3'h1; cmd = 1;
        wait_bit(CSW_ON_LINE, 1);
        chk("word on line", 16'ha, 16'(csw));
        cmd = 0;
        wait_bit(CSW_LINE_CLOSE, 0);
        chk("return delay", 16'h1, 16'(c >= 12));
        wait_bit(4, 1);
        chk("word back", 16'h1, 16'(csw));
    endtask : t_unsync_ctrl
    task automatic t_speed();
        trig = 3'h2; thr = 16'h64; spd = 16'h64; ramp = 16'h64;
        step(40);
        chk("equal speed stays", 16'h1, 16'(csw));
        spd = 16'h65;
        wait_bit(CSW_ON_LINE, 1);
        step(40);
        chk("ramp at threshold", 16'ha, 16'(csw));
        ramp = 16'h63; spd = 16'h63;
        wait_bit(4, 1);
    endtask : t_speed
    task automatic t_fault();
        trig = 3'h4; on_cmd = 1; slow = 1;
        step(30);
        fault = 1;
        wait_bit(CSW_CONV_CLOSE, 0);
        chk("bypass delay", 16'h1, 16'(c >= 8));
        wait_bit(CSW_ON_LINE, 1);
        fault = 0; on_cmd = 0;
        step(40);
        chk("on command needed", 16'ha, 16'(csw));
        on_cmd = 1;
        wait_bit(CSW_LINE_CLOSE, 0);
        chk("debypass delay", 16'h1, 16'(c >= 12));
        wait_bit(4, 1);
        chk("word back", 16'h1, 16'(csw));
        slow = 0; on_cmd = 0;
    endtask : t_fault
    task automatic t_sync();
        mode = MODE_SYNC_NOOV; trig = 3'h3; cmd = 1; spd = 16'hc8;
        step(60);
        chk("refused source", 16'h1, 16'(csw));
        trig = 3'h1; spd = 16'h0;
        wait_bit(CSW_SYNC_REQ, 1);
        chk("sync enable", 16'h1, 16'(sync_en));
        step(20);
        chk("waits synchronism", 16'h1, 16'(csw[0]));
        sync_w = 4'h4;
        wait_bit(CSW_LINE_CLOSE, 1);
        chk("converter open", 16'h0, 16'(csw[0]));
        phase = 16'h2345;
        step(2);
        chk("phase lead", 16'h2345, lead);
    endtask : t_sync
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        step(12);
        rst = 0;
        step(2);
        chk("word after reset", 16'h11, 16'(st));
        chk("sync source", 16'(SYNC_SRC_MODEL), 16'(src));
        t_unsync_ctrl();
        t_speed();
        t_fault();
        t_sync();
        final_report();
    end
endmodule : tb_bypass_contactor_sequencer
`default_nettype wire
